//--- hw/apar_mdio_serial.sv
// Purpose: serial management slave, turns frames into register requests
// Assumes: mdc and mdio_in synchronous to clk_sys and much slower than it
// Notes: bits sampled and driven on the rising edge of mdc
`timescale 1ns/1ns
`default_nettype none
module apar_mdio_serial
    import apar_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = PHY_ADDR_DFLT,
    parameter int PRE_LEN = PRE_LEN_DFLT
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    apar_mgmt_if.serial_side mgmt
);
    if (PRE_LEN < 1 || PRE_LEN > PRE_LEN_MAX) begin : g_chk
        $error("preamble length out of range");
    end

    apar_mdio_state_e state, next_state;
    logic mdc_q, next_mdc_q;
    logic [5:0] pre_cnt, next_pre_cnt;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [15:0] shreg, next_shreg;
    logic is_rd, next_is_rd;
    logic next_mdio_out, next_mdio_oe;
    logic rd_req, next_rd_req, wr_req, next_wr_req;
    logic [4:0] addr, next_addr;
    logic [15:0] wdata, next_wdata;
    logic [12:0] hdr;
    logic rise;

    assign mgmt.rd_req = rd_req;
    assign mgmt.wr_req = wr_req;
    assign mgmt.addr = addr;
    assign mgmt.wdata = wdata;

    // ------------------------------------------------------------
    // frame decoding
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_mdc_q = mdc;
        next_pre_cnt = pre_cnt;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_is_rd = is_rd;
        next_mdio_out = mdio_out;
        next_mdio_oe = mdio_oe;
        next_rd_req = 1'b0;
        next_wr_req = 1'b0;
        next_addr = addr;
        next_wdata = wdata;
        rise = mdc & ~mdc_q;
        hdr = {shreg[11:0], mdio_in};
        if (rise) begin
            unique case (state)
                MS_PRE: begin
                    if (mdio_in) begin
                        if (pre_cnt < 6'(PRE_LEN)) begin
                            next_pre_cnt = pre_cnt + 6'h01;
                        end
                    end else begin
                        next_pre_cnt = 6'h00;
                        if (pre_cnt >= 6'(PRE_LEN)) begin
                            next_state = MS_HDR;
                            next_bit_cnt = 5'h00;
                        end
                    end
                end
                MS_HDR: begin
                    next_shreg = {shreg[14:0], mdio_in};
                    next_bit_cnt = bit_cnt + 5'h01;
                    if (bit_cnt == HDR_LAST) begin
                        next_state = MS_PRE;
                        if (hdr[12] && hdr[9:5] == PHY_ADDR && (hdr[11:10] == OP_RD || hdr[11:10] == OP_WR)) begin
                            next_state = MS_TA;
                            next_is_rd = (hdr[11:10] == OP_RD);
                            next_rd_req = (hdr[11:10] == OP_RD);
                            next_addr = hdr[4:0];
                            next_bit_cnt = 5'h00;
                        end
                    end
                end
                MS_TA: begin
                    if (bit_cnt == 5'h00) begin
                        next_bit_cnt = 5'h01;
                        if (is_rd) begin
                            next_mdio_oe = 1'b1;
                            next_mdio_out = 1'b0;
                            next_shreg = mgmt.rdata;
                        end
                    end else begin
                        next_bit_cnt = 5'h00;
                        next_state = is_rd ? MS_RD : MS_WR;
                        if (is_rd) begin
                            next_mdio_out = shreg[15];
                            next_shreg = {shreg[14:0], 1'b0};
                        end
                    end
                end
                MS_RD: begin
                    next_bit_cnt = bit_cnt + 5'h01;
                    if (bit_cnt == DATA_LAST) begin
                        next_mdio_oe = 1'b0;
                        next_mdio_out = 1'b0;
                        next_state = MS_PRE;
                    end else begin
                        next_mdio_out = shreg[15];
                        next_shreg = {shreg[14:0], 1'b0};
                    end
                end
                MS_WR: begin
                    next_shreg = {shreg[14:0], mdio_in};
                    next_bit_cnt = bit_cnt + 5'h01;
                    if (bit_cnt == DATA_LAST) begin
                        next_wdata = {shreg[14:0], mdio_in};
                        next_wr_req = 1'b1;
                        next_state = MS_PRE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= MS_PRE;
            mdc_q <= 1'b0;
            pre_cnt <= 6'h00;
            bit_cnt <= 5'h00;
            shreg <= 16'h0000;
            is_rd <= 1'b0;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
            rd_req <= 1'b0;
            wr_req <= 1'b0;
            addr <= 5'h00;
            wdata <= 16'h0000;
        end else begin
            state <= next_state;
            mdc_q <= next_mdc_q;
            pre_cnt <= next_pre_cnt;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            is_rd <= next_is_rd;
            mdio_out <= next_mdio_out;
            mdio_oe <= next_mdio_oe;
            rd_req <= next_rd_req;
            wr_req <= next_wr_req;
            addr <= next_addr;
            wdata <= next_wdata;
        end
    end
endmodule
`default_nettype wire

//--- hw/apar_mgmt_if.sv
// Purpose: register access path between serial front end and register store
// Assumes: requests are one-cycle pulses on clk_sys
// Notes: rdata is registered by the register side
`timescale 1ns/1ns
`default_nettype none
interface apar_mgmt_if;
    logic rd_req;
    logic wr_req;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport serial_side (output rd_req, output wr_req, output addr, output wdata, input rdata);
    modport reg_side (input rd_req, input wr_req, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- hw/apar_partner_ability.sv
// Purpose: link partner ability register with serial management access
// Assumes: the negotiation engine presents each received base page with cw_valid
// Notes: override_en mirrors the command override control bit of another register
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - register loads from the partner code word received during negotiation
// - bit 15 shows partner next page flag
// - bit 14 shows partner acknowledge flag
// - bit 13 shows partner remote fault flag
// - bits 8 to 5 filled from partner technology ability bits
// - reserved bits 12 to 10 always read zero
// - bit 9, the T4 ability, always reads zero
// - bits 8 to 5 show partner 100 and 10 megabit duplex abilities
// - bits 4 to 0 hold partner selector; only 802.3 code supported
// - selector 00010b recognised as valid but not supported
// - override-gated bits writable only while override control bit is one
module apar_partner_ability
    import apar_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = PHY_ADDR_DFLT,
    parameter int PRE_LEN = PRE_LEN_DFLT
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic cw_valid,
    input wire logic [15:0] cw_data,
    input wire logic override_en,
    output logic lp_page_loaded,
    output logic lp_sel_supported,
    output logic lp_sel_known
);
    apar_mgmt_if mgmt();

    logic [15:0] lpa, next_lpa;
    logic [15:0] rdata, next_rdata;
    logic next_page_loaded, next_sel_supported, next_sel_known;
    logic gated_wr;

    function automatic logic hits_lpa(input logic [4:0] a);
        return a == REG_LPA;
    endfunction

    // ------------------------------------------------------------
    // serial front end
    // ------------------------------------------------------------
    apar_mdio_serial #(
        .PHY_ADDR(PHY_ADDR),
        .PRE_LEN(PRE_LEN)
    ) u_serial (
        .clk_sys(clk_sys),
        .rst(rst),
        .mdc(mdc),
        .mdio_in(mdio_in),
        .mdio_out(mdio_out),
        .mdio_oe(mdio_oe),
        .mgmt(mgmt.serial_side)
    );

    assign mgmt.rdata = rdata;

    // ------------------------------------------------------------
    // register store
    // ------------------------------------------------------------
    always_comb begin
        next_lpa = lpa;
        next_page_loaded = lp_page_loaded;
        gated_wr = mgmt.wr_req && hits_lpa(mgmt.addr) && override_en && lp_page_loaded;
        if (cw_valid) begin
            next_lpa = cw_data & LPA_CAPT_MASK;
            next_page_loaded = 1'b1;
        end else if (gated_wr) begin
            next_lpa = (lpa & ~LPA_OVR_MASK) | (mgmt.wdata & LPA_OVR_MASK);
        end
        next_sel_supported = next_lpa[LPA_SEL_HI:0] == SEL_IEEE8023;
        next_sel_known = next_sel_supported || next_lpa[LPA_SEL_HI:0] == SEL_IEEE8029;
        next_rdata = rdata;
        if (mgmt.rd_req) begin
            next_rdata = hits_lpa(mgmt.addr) ? lpa : 16'h0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lpa <= LPA_RESET;
            lp_page_loaded <= 1'b0;
            lp_sel_supported <= 1'b0;
            lp_sel_known <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            lpa <= next_lpa;
            lp_page_loaded <= next_page_loaded;
            lp_sel_supported <= next_sel_supported;
            lp_sel_known <= next_sel_known;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_capture;
        cw_valid;
    endsequence

    sequence s_blocked_write;
        mgmt.wr_req && hits_lpa(mgmt.addr) && !override_en && !cw_valid;
    endsequence

    sequence s_plain_write;
        mgmt.wr_req && !cw_valid;
    endsequence

    a_capture_load: assert property (s_capture |=> lpa == ($past(cw_data) & LPA_CAPT_MASK))
        else $error("captured word not loaded");
    a_next_page: assert property (s_capture |=> lpa[LPA_NP_BIT] == $past(cw_data[LPA_NP_BIT]))
        else $error("next page flag wrong");
    a_ack_flag: assert property (s_capture |=> lpa[LPA_ACK_BIT] == $past(cw_data[LPA_ACK_BIT]))
        else $error("acknowledge flag wrong");
    a_remote_fault: assert property (s_capture |=> lpa[LPA_RF_BIT] == $past(cw_data[LPA_RF_BIT]))
        else $error("remote fault flag wrong");
    a_tech_field: assert property (s_capture |=> lpa[8:LPA_TAF_LO] == $past(cw_data[8:LPA_TAF_LO]))
        else $error("technology field wrong");
    a_abilities_held: assert property (s_capture ##1 !cw_valid |=> $stable(lpa[8:LPA_TAF_LO]))
        else $error("abilities changed without a code word");
    a_reserved_zero: assert property (lpa[LPA_RSV_HI:LPA_RSV_LO] == 3'h0 && rdata[LPA_RSV_HI:LPA_RSV_LO] == 3'h0)
        else $error("reserved bits not zero");
    a_t4_zero: assert property (!lpa[LPA_T4_BIT] && !rdata[LPA_T4_BIT])
        else $error("t4 ability not zero");
    a_sel_flags: assert property (s_capture |=> lp_sel_supported == ($past(cw_data[LPA_SEL_HI:0]) == SEL_IEEE8023))
        else $error("selector support flag wrong");
    a_sel_8029: assert property (lpa[LPA_SEL_HI:0] == SEL_IEEE8029 |-> lp_sel_known && !lp_sel_supported)
        else $error("second selector code mishandled");
    a_override_gate: assert property (s_blocked_write |=> $stable(lpa))
        else $error("write taken without override");
    a_readonly_bits: assert property (s_plain_write |=> $stable(lpa[15:4]))
        else $error("read-only bits written");
    a_zero_until_word: assert property (!lp_page_loaded |-> lpa == LPA_RESET)
        else $error("register not zero before first word");
endmodule
`default_nettype wire

//--- hw/apar_pkg.sv
// Purpose: shared constants and types for the partner ability register block
// Assumes: 16-bit management registers, 5-bit register and station addresses
// Notes: field masks describe which bits hold captured or writable data
package apar_pkg;
    localparam logic [4:0] REG_LPA = 5'h05;
    localparam logic [4:0] PHY_ADDR_DFLT = 5'h01;
    localparam int PRE_LEN_DFLT = 32;
    localparam int PRE_LEN_MAX = 32;
    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int LPA_NP_BIT = 15;
    localparam int LPA_ACK_BIT = 14;
    localparam int LPA_RF_BIT = 13;
    localparam int LPA_TAF_HI = 12;
    localparam int LPA_TAF_LO = 5;
    localparam int LPA_RSV_HI = 12;
    localparam int LPA_RSV_LO = 10;
    localparam int LPA_T4_BIT = 9;
    localparam int LPA_SEL_HI = 4;
    localparam logic [15:0] LPA_RESET = 16'h0000;
    localparam logic [15:0] LPA_CAPT_MASK = 16'he1ff;
    localparam logic [15:0] LPA_OVR_MASK = 16'h000f;
    localparam logic [4:0] SEL_IEEE8023 = 5'h01;
    localparam logic [4:0] SEL_IEEE8029 = 5'h02;
    // ------------------------------------------------------------
    // serial management frame
    // ------------------------------------------------------------
    localparam logic [1:0] OP_RD = 2'h2;
    localparam logic [1:0] OP_WR = 2'h1;
    localparam logic [4:0] HDR_LAST = 5'h0c;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    typedef enum logic [2:0] {MS_PRE, MS_HDR, MS_TA, MS_RD, MS_WR} apar_mdio_state_e;
endpackage

//--- verif/apar_sta_model.sv
// Purpose: station management model driving serial management frames
// Assumes: mdc half period of four clk_sys cycles, mdc idle low between frames
// Notes: line released during read turnaround and data; pull-up in bench
`timescale 1ns/1ns
`default_nettype none
module apar_sta_model
    import apar_pkg::*;
#(
    parameter int PRE = 4
)(
    input wire logic clk_sys,
    output logic mdc,
    output logic sta_oe,
    output logic sta_out,
    input wire logic mdio_line,
    input wire logic phy_oe
);
    logic got_oe;
    initial begin
        mdc = 1'b0;
        sta_oe = 1'b0;
        sta_out = 1'b0;
        got_oe = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task automatic send_bit(input logic b);
        sta_oe = 1'b1;
        sta_out = b;
        half();
        mdc = 1'b1;
        half();
        mdc = 1'b0;
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        int i;
        hdr = {2'b01, op, pa, ra};
        got_oe = 1'b0;
        rd = 16'h0000;
        for (i = 0; i < PRE; i++) send_bit(1'b1);
        for (i = 13; i >= 0; i--) send_bit(hdr[i]);
        if (op == OP_WR) begin
            send_bit(1'b1);
            send_bit(1'b0);
            for (i = 15; i >= 0; i--) send_bit(wd[i]);
        end else begin
            sta_oe = 1'b0;
            for (i = 0; i < 18; i++) begin
                half();
                mdc = 1'b1;
                half();
                if (phy_oe) got_oe = 1'b1;
                if (i >= 1 && i <= 16) rd = {rd[14:0], mdio_line};
                mdc = 1'b0;
            end
        end
        sta_oe = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench for the partner ability register
// Assumes: short preamble parameter, station model on the serial pins
// Notes: expected register kept by a bench model updated on capture and write
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import apar_pkg::*;
    localparam int PRE = 4;
    logic clk_sys, rst, cw_valid, override_en, mdc, sta_oe, sta_out;
    logic mdio_out, mdio_oe, mdio_line, lp_page_loaded, lp_sel_supported, lp_sel_known;
    logic [15:0] cw_data, exp_reg, rd, w;
    logic exp_loaded;
    int err_count, comparisons, i;
    logic [4:0] sels [6] = '{5'h01, 5'h02, 5'h00, 5'h03, 5'h1f, 5'h01};
    assign mdio_line = mdio_oe ? mdio_out : (sta_oe ? sta_out : 1'b1);
    apar_partner_ability #(.PHY_ADDR(PHY_ADDR_DFLT), .PRE_LEN(PRE)) uut (
        .clk_sys(clk_sys), .rst(rst), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .cw_valid(cw_valid), .cw_data(cw_data), .override_en(override_en),
        .lp_page_loaded(lp_page_loaded), .lp_sel_supported(lp_sel_supported), .lp_sel_known(lp_sel_known));
    apar_sta_model #(.PRE(PRE)) sta (
        .clk_sys(clk_sys), .mdc(mdc), .sta_oe(sta_oe), .sta_out(sta_out),
        .mdio_line(mdio_line), .phy_oe(mdio_oe));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // check and report
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("err_count=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_flags();
        logic sup, known;
        repeat (2) @(posedge clk_sys);
        #1;
        sup = exp_reg[LPA_SEL_HI:0] == SEL_IEEE8023;
        known = sup || exp_reg[LPA_SEL_HI:0] == SEL_IEEE8029;
        chk({13'h0000, lp_page_loaded, lp_sel_supported, lp_sel_known}, {13'h0000, exp_loaded, sup, known});
    endtask
    task automatic rd5(input logic [4:0] ra, input logic [15:0] exp);
        sta.frame(OP_RD, PHY_ADDR_DFLT, ra, 16'h0000, rd);
        chk(rd, exp);
        chk({15'h0000, sta.got_oe}, 16'h0001);
        chk({15'h0000, mdio_oe}, 16'h0000);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        sta.frame(OP_WR, PHY_ADDR_DFLT, ra, wd, rd);
        if (ra == REG_LPA && override_en && exp_loaded) exp_reg[3:0] = wd[3:0];
    endtask
    task automatic capture(input logic [15:0] cw);
        cw_valid = 1'b1;
        cw_data = cw;
        @(posedge clk_sys);
        #1;
        cw_valid = 1'b0;
        cw_data = 16'($urandom);
        exp_reg = cw & LPA_CAPT_MASK;
        exp_loaded = 1'b1;
    endtask
    initial begin
        #1_000_000;
        err_count++;
        summarize();
    end
    initial begin
        void'($urandom(14779));
        rst = 1'b1;
        cw_valid = 1'b0;
        cw_data = 16'h0000;
        override_en = 1'b0;
        err_count = 0;
        comparisons = 0;
        exp_reg = 16'h0000;
        exp_loaded = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk_flags();
        rd5(REG_LPA, 16'h0000);
        override_en = 1'b1;
        wr(REG_LPA, 16'h000f);
        rd5(REG_LPA, 16'h0000);
        for (i = 0; i < 8; i++) begin
            w = 16'($urandom);
            if (i < 6) w[4:0] = sels[i];
            if (i == 0) w = 16'hffff;
            capture(w);
            chk_flags();
            rd5(REG_LPA, exp_reg);
            chk({12'h000, rd[12:9]}, 16'h0000);
        end
        cw_valid = 1'b1;
        cw_data = 16'h5555;
        @(posedge clk_sys);
        #1;
        cw_data = 16'haaaa;
        @(posedge clk_sys);
        #1;
        cw_valid = 1'b0;
        exp_reg = 16'haaaa & LPA_CAPT_MASK;
        chk_flags();
        rd5(REG_LPA, exp_reg);
        override_en = 1'b0;
        wr(REG_LPA, 16'he3ff);
        rd5(REG_LPA, exp_reg);
        override_en = 1'b1;
        wr(REG_LPA, 16'he3f5);
        rd5(REG_LPA, exp_reg);
        wr(5'h06, 16'h1234);
        rd5(5'h06, 16'h0000);
        sta.frame(OP_RD, 5'h00, REG_LPA, 16'h0000, rd);
        chk({15'h0000, sta.got_oe}, 16'h0000);
        rd5(REG_LPA, exp_reg);
        rst = 1'b1;
        @(posedge clk_sys);
        #1;
        rst = 1'b0;
        exp_reg = 16'h0000;
        exp_loaded = 1'b0;
        chk_flags();
        rd5(REG_LPA, 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
